//--- bench/orgr_regs_checker.sv
`timescale 1ns/1ps
`include "orgr_regs.svh"
module orgr_regs_checker
    import orgr_pkg::*;
(
    // Clock, reset and bus
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ORGR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    // Routing and drivers
    input wire logic left_line_output_from_rneg,
    input wire logic left_line_output_from_ldac,
    input wire logic left_line_output_from_left_mixer_amplifier,
    input wire logic left_line_output_from_right_line_output,
    input wire logic right_line_output_from_rdac,
    input wire logic right_line_output_from_right_mixer_amplifier,
    input wire logic left_headphone_driver_mute,
    input wire orgr_gain_t left_headphone_driver_gain,
    input wire logic right_headphone_driver_mute,
    input wire orgr_gain_t right_headphone_driver_gain,
    input wire logic headphone_mute_unreliable,
    input wire logic left_line_output_mute,
    input wire orgr_gain_t left_line_output_gain
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire wr = psel && penable && pwrite && pstrb[0];
    wire rd = psel && penable && !pwrite;
    wire w_left_route = wr && paddr == 12'h038;
    wire w_right_route = wr && paddr == 12'h03C;
    wire w_left_hp = wr && paddr == 12'h040;
    wire w_right_hp = wr && paddr == 12'h044;
    wire w_line = wr && paddr == 12'h048;
    a_route_rneg: assert property (w_left_route |=>
        left_line_output_from_rneg == $past(pwdata[4])) else $error("rneg");
    a_route_ldac: assert property (w_left_route |=>
        left_line_output_from_ldac == $past(pwdata[3])) else $error("ldac");
    a_route_lmix: assert property (w_left_route |=>
        left_line_output_from_left_mixer_amplifier == $past(pwdata[1]))
        else $error("lmix");
    a_route_loop: assert property (w_left_route |=>
        left_line_output_from_right_line_output == $past(pwdata[0]))
        else $error("loop");
    a_route_rdac: assert property (w_right_route |=>
        right_line_output_from_rdac == $past(pwdata[3])) else $error("rdac");
    a_route_rmix: assert property (w_right_route |=>
        right_line_output_from_right_mixer_amplifier == $past(pwdata[1]))
        else $error("rmix");
    a_rsvd_zero: assert property (rd |->
        prdata[31:7] == 25'h0
        && (paddr != 12'h038 || prdata[6:5] == 2'h0 && !prdata[2])
        && (paddr != 12'h03C || prdata[6:4] == 3'h0 && !prdata[2]
        && !prdata[0])) else $error("reserved bits");
    a_lhp_field: assert property (w_left_hp |=>
        {left_headphone_driver_mute, left_headphone_driver_gain}
        == $past(pwdata[6:0])) else $error("left hp field");
    a_rhp_field: assert property (w_right_hp |=>
        {right_headphone_driver_mute, right_headphone_driver_gain}
        == $past(pwdata[6:0])) else $error("right hp field");
    a_line_field: assert property (w_line |=>
        {left_line_output_mute, left_line_output_gain}
        == $past(pwdata[6:0])) else $error("line field");
    a_mute_flag: assert property (headphone_mute_unreliable ==
        (left_headphone_driver_mute && left_headphone_driver_gain == 6'h3A
        || right_headphone_driver_mute && right_headphone_driver_gain
        == 6'h3A)) else $error("unreliable flag");
    a_reset_vals: assert property ($rose(rstn) |->
        left_headphone_driver_mute && right_headphone_driver_mute &&
        left_line_output_mute && left_line_output_gain == 6'h0 &&
        left_headphone_driver_gain == 6'h0 &&
        right_headphone_driver_gain == 6'h0) else $error("reset values");
endmodule
bind orgr_regs_top orgr_regs_checker orgr_regs_checker_inst (
    .sys_clk,
    .rstn,
    .psel,
    .penable,
    .pwrite,
    .paddr,
    .pwdata,
    .pstrb,
    .prdata,
    .left_line_output_from_rneg,
    .left_line_output_from_ldac,
    .left_line_output_from_left_mixer_amplifier,
    .left_line_output_from_right_line_output,
    .right_line_output_from_rdac,
    .right_line_output_from_right_mixer_amplifier,
    .left_headphone_driver_mute,
    .left_headphone_driver_gain,
    .right_headphone_driver_mute,
    .right_headphone_driver_gain,
    .headphone_mute_unreliable,
    .left_line_output_mute,
    .left_line_output_gain
);

//--- bench/orgr_regs_tb_top.sv
`timescale 1ns/1ps
`include "orgr_regs.svh"
module orgr_regs_tb_top
    import orgr_pkg::*;
;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [`ORGR_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, d;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, hm, hok, qm, qok, unr, lm, lok;
    wire [5:0] rt;
    orgr_gain_t hg, qg, lg;
    int fail_count = 0, cmp_count = 0, k;
    orgr_byte_t mem [5];
    localparam orgr_byte_t MASK [5] = '{8'h1B, 8'h0A, 8'h7F, 8'h7F, 8'h7F};
    localparam int CK [8] = '{2, 3, 2, 4, 4, 3, 0, 1};
    localparam orgr_byte_t CD [8] = '{8'h7A, 8'h4E, 8'h0F, 8'h5D, 8'h1E,
        8'hB9, 8'hFF, 8'hFF};
    wire [31:0] obs = {rt, hm, hg, qm, qg, lm, lg, hok, qok, lok, unr, 1'b0};
    orgr_regs_top orgr_regs_top_inst (.sys_clk, .rstn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .left_line_output_from_rneg(rt[5]), .left_line_output_from_ldac(rt[4]),
        .left_line_output_from_left_mixer_amplifier(rt[3]),
        .left_line_output_from_right_line_output(rt[2]),
        .right_line_output_from_rdac(rt[1]),
        .right_line_output_from_right_mixer_amplifier(rt[0]),
        .left_headphone_driver_mute(hm), .left_headphone_driver_gain(hg),
        .left_headphone_driver_gain_ok(hok), .right_headphone_driver_mute(qm),
        .right_headphone_driver_gain(qg), .right_headphone_driver_gain_ok(qok),
        .headphone_mute_unreliable(unr), .left_line_output_mute(lm),
        .left_line_output_gain(lg), .left_line_output_gain_ok(lok));
    initial forever #4 sys_clk = ~sys_clk;
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    function automatic logic okf(input logic [5:0] c, input int mx);
        return $signed(c) >= -6 && $signed(c) <= mx;
    endfunction
    // Random writes keep reserved bits zero and gain codes in range.
    // legal writes
    function automatic logic [31:0] legal(input int k, input logic [31:0] v);
        int span;
        span = k == 4 ? 36 : 21;
        if (k < 2) return {24'h0, v[7:0] & MASK[k]};
        return {25'h0, v[6], 6'(int'(v[31:8] % span) - 6)};
    endfunction
    function automatic logic [31:0] expv();
        logic [5:0] h = mem[2][5:0], q = mem[3][5:0], l = mem[4][5:0];
        return {mem[0][4:3], mem[0][1:0], mem[1][3], mem[1][1], mem[2][6:0],
            mem[3][6:0], mem[4][6:0], okf(h, 14), okf(q, 14), okf(l, 29),
            mem[2][6] && h == 6'h3A || mem[3][6] && q == 6'h3A, 1'b0};
    endfunction
    // The bus signals are held until pready is seen at an access edge, or for at most 20 access edges.
    task apb(input logic w, input logic [`ORGR_ADDR_W-1:0] a,
        input logic [31:0] dv);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dv;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) fail_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(28876));
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (mem[i]) mem[i] = i < 2 ? 8'h00 : 8'h40;
        foreach (mem[i]) begin
            apb(1'b0, 12'(12'h038 + 4 * i), 32'h0);
            chk(r, {24'h0, mem[i]});
        end
        for (int t = 0; t < 48; t++) begin
            k = t < 8 ? CK[t] : int'($urandom % 5);
            d = t < 8 ? {24'h0, CD[t]} : legal(k, $urandom);
            apb(1'b1, 12'(12'h038 + 4 * k), d);
            mem[k] = d[7:0] & MASK[k];
            apb(1'b0, 12'(12'h038 + 4 * k), 32'h0);
            chk(r, {24'h0, mem[k]});
            chk(obs, expv());
        end
        // Refused accesses must leave every register as it was.
        pstrb <= 4'h0;
        apb(1'b1, 12'h040, 32'h15);
        pstrb <= 4'hF;
        apb(1'b1, 12'h04C, 32'hFF);
        chk({31'h0, e}, 32'h1);
        // An unaligned read is refused and leaves the read data as it was.
        d = r;
        apb(1'b0, 12'h039, 32'h0);
        chk(r, d);
        chk({31'h0, e}, 32'h1);
        chk(obs, expv());
        rstn <= 1'b0;
        @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (mem[i]) mem[i] = i < 2 ? 8'h00 : 8'h40;
        @(posedge sys_clk);
        chk(obs, expv());
        conclude;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        conclude;
    end
endmodule

//--- rtl/orgr_gain_reg.sv
`timescale 1ns/1ps
`include "orgr_regs.svh"
module orgr_gain_reg
    import orgr_pkg::*;
#(
    parameter logic [5:0] GAIN_MAX = `ORGR_HP_GAIN_MAX
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Register and decoded fields
    output orgr_byte_t value,
    output logic mute,
    output orgr_gain_t gain_db,
    output logic gain_valid
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // mute resets set
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            value <= `ORGR_GAIN_RESET;
        end else if (wr_en) begin
            value <= wr_data & `ORGR_GAIN_MASK;
        end
    end

    assign mute = value[`ORGR_BIT_MUTE];
    assign gain_db = orgr_gain_t'(value[`ORGR_GAIN_HI:0]);
    assign gain_valid = (gain_db >= orgr_gain_t'(`ORGR_GAIN_MIN))
        && (gain_db <= orgr_gain_t'(GAIN_MAX));
endmodule

//--- rtl/orgr_pkg.sv
package orgr_pkg;
    typedef logic signed [5:0] orgr_gain_t;
    typedef logic [7:0] orgr_byte_t;
endpackage

//--- rtl/orgr_regs.svh
// Contract
// - Left line routing bit 4 routes the right filter negative terminal to the left line output.
// - Left line routing bit 3 routes the left filter output to the left line output.
// - Left line routing bit 1 routes the left mixer amplifier to the left line output.
// - Left line routing bit 0 feeds the right line output into the left line output.
// - Right line routing bit 3 routes the right filter output to the right line output.
// - Right line routing bit 1 routes the right mixer amplifier to the right line output.
// - Upper reserved routing fields read as zero and take only zero writes.
// - Single reserved bits in routing and gain registers are read-only zero.
// - Headphone gain bit 6 mutes its driver and resets to one.
// - Left line gain bit 6 mutes its driver and resets to one.
// - Headphone gain codes run from minus six to plus fourteen dB.
// - Every gain field resets to code zero, applied as zero dB.
// - Left line gain codes run from minus six to plus twenty-nine dB.
// - Mute is not guaranteed to silence a headphone driver at minus six dB.
`ifndef ORGR_REGS_SVH
`define ORGR_REGS_SVH

// ----------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------
`define ORGR_IDX_LEFT_ROUTE 8'h0E
`define ORGR_IDX_RIGHT_ROUTE 8'h0F
`define ORGR_IDX_LEFT_HP_GAIN 8'h10
`define ORGR_IDX_RIGHT_HP_GAIN 8'h11
`define ORGR_IDX_LEFT_LINE_GAIN 8'h12
`define ORGR_ADDR_W 12

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define ORGR_LEFT_ROUTE_MASK 8'h1B
`define ORGR_RIGHT_ROUTE_MASK 8'h0A
`define ORGR_GAIN_MASK 8'h7F
`define ORGR_ROUTE_RESET 8'h00
`define ORGR_GAIN_RESET 8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ORGR_BIT_RNEG 4
`define ORGR_BIT_DAC 3
`define ORGR_BIT_MIX 1
`define ORGR_BIT_LOOP 0
`define ORGR_BIT_MUTE 6
`define ORGR_GAIN_HI 5

// ----------------------------------------
// Gain code limits
// ----------------------------------------
`define ORGR_GAIN_MIN 6'h3A
`define ORGR_HP_GAIN_MAX 6'h0E
`define ORGR_LINE_GAIN_MAX 6'h1D

`endif

//--- rtl/orgr_regs_top.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "orgr_regs.svh"
module orgr_regs_top
    import orgr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ORGR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Left line output routing
    output logic left_line_output_from_rneg,
    output logic left_line_output_from_ldac,
    output logic left_line_output_from_left_mixer_amplifier,
    output logic left_line_output_from_right_line_output,
    // Right line output routing
    output logic right_line_output_from_rdac,
    output logic right_line_output_from_right_mixer_amplifier,
    // Headphone drivers
    output logic left_headphone_driver_mute,
    output orgr_gain_t left_headphone_driver_gain,
    output logic left_headphone_driver_gain_ok,
    output logic right_headphone_driver_mute,
    output orgr_gain_t right_headphone_driver_gain,
    output logic right_headphone_driver_gain_ok,
    output logic headphone_mute_unreliable,
    // Left line driver
    output logic left_line_output_mute,
    output orgr_gain_t left_line_output_gain,
    output logic left_line_output_gain_ok
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Access completes in its first access cycle, so no wait states.
    wire [`ORGR_ADDR_W-3:0] word_idx = paddr[`ORGR_ADDR_W-1:2];
    wire hit_left_route =
        word_idx == (`ORGR_ADDR_W-2)'(`ORGR_IDX_LEFT_ROUTE);
    wire hit_right_route =
        word_idx == (`ORGR_ADDR_W-2)'(`ORGR_IDX_RIGHT_ROUTE);
    wire hit_left_hp =
        word_idx == (`ORGR_ADDR_W-2)'(`ORGR_IDX_LEFT_HP_GAIN);
    wire hit_right_hp =
        word_idx == (`ORGR_ADDR_W-2)'(`ORGR_IDX_RIGHT_HP_GAIN);
    wire hit_left_line =
        word_idx == (`ORGR_ADDR_W-2)'(`ORGR_IDX_LEFT_LINE_GAIN);
    wire hit_any = hit_left_route | hit_right_route | hit_left_hp
        | hit_right_hp | hit_left_line;
    wire aligned = paddr[1:0] == 2'h0;
    wire access = psel & penable;
    // A write without the low byte lane enabled changes nothing.
    wire wr_ok = access & pwrite & hit_any & aligned & pstrb[0];
    wire [7:0] wbyte = pwdata[7:0];

    assign pready = 1'b1;
    assign pslverr = access & ~(hit_any & aligned);

    // ----------------------------------------
    // Routing registers
    // ----------------------------------------
    orgr_byte_t left_line_out_routing;
    orgr_byte_t right_line_out_routing;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            left_line_out_routing <= `ORGR_ROUTE_RESET;
        end else if (wr_ok && hit_left_route) begin
            left_line_out_routing <= wbyte & `ORGR_LEFT_ROUTE_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            right_line_out_routing <= `ORGR_ROUTE_RESET;
        end else if (wr_ok && hit_right_route) begin
            right_line_out_routing <= wbyte & `ORGR_RIGHT_ROUTE_MASK;
        end
    end

    assign left_line_output_from_rneg =
        left_line_out_routing[`ORGR_BIT_RNEG];
    assign left_line_output_from_ldac =
        left_line_out_routing[`ORGR_BIT_DAC];
    assign left_line_output_from_left_mixer_amplifier =
        left_line_out_routing[`ORGR_BIT_MIX];
    assign left_line_output_from_right_line_output =
        left_line_out_routing[`ORGR_BIT_LOOP];
    assign right_line_output_from_rdac =
        right_line_out_routing[`ORGR_BIT_DAC];
    assign right_line_output_from_right_mixer_amplifier =
        right_line_out_routing[`ORGR_BIT_MIX];

    // ----------------------------------------
    // Gain and mute registers
    // ----------------------------------------
    orgr_byte_t left_headphone_gain_mute;
    orgr_byte_t right_headphone_gain_mute;
    orgr_byte_t left_line_gain_mute;

    orgr_gain_reg #(
        .GAIN_MAX(`ORGR_HP_GAIN_MAX)
    ) u_left_headphone (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_ok & hit_left_hp),
        .wr_data(wbyte),
        .value(left_headphone_gain_mute),
        .mute(left_headphone_driver_mute),
        .gain_db(left_headphone_driver_gain),
        .gain_valid(left_headphone_driver_gain_ok)
    );

    orgr_gain_reg #(
        .GAIN_MAX(`ORGR_HP_GAIN_MAX)
    ) u_right_headphone (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_ok & hit_right_hp),
        .wr_data(wbyte),
        .value(right_headphone_gain_mute),
        .mute(right_headphone_driver_mute),
        .gain_db(right_headphone_driver_gain),
        .gain_valid(right_headphone_driver_gain_ok)
    );

    orgr_gain_reg #(
        .GAIN_MAX(`ORGR_LINE_GAIN_MAX)
    ) u_left_line (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_ok & hit_left_line),
        .wr_data(wbyte),
        .value(left_line_gain_mute),
        .mute(left_line_output_mute),
        .gain_db(left_line_output_gain),
        .gain_valid(left_line_output_gain_ok)
    );

    // The analog stage cannot guarantee mute at the lowest headphone gain,
    // so this flag warns that a requested mute may leak audio.
    // mute not guaranteed
    assign headphone_mute_unreliable =
        (left_headphone_driver_mute && left_headphone_driver_gain ==
            orgr_gain_t'(`ORGR_GAIN_MIN))
        || (right_headphone_driver_mute && right_headphone_driver_gain ==
            orgr_gain_t'(`ORGR_GAIN_MIN));

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [7:0] rd_byte =
        ({8{hit_left_route}} & left_line_out_routing)
        | ({8{hit_right_route}} & right_line_out_routing)
        | ({8{hit_left_hp}} & left_headphone_gain_mute)
        | ({8{hit_right_hp}} & right_headphone_gain_mute)
        | ({8{hit_left_line}} & left_line_gain_mute);
    wire rd_ok = psel & ~penable & ~pwrite & aligned;

    // Read data is captured in the setup cycle so prdata is a register
    // yet valid in the single access cycle.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (rd_ok) begin
            prdata <= {24'h000000, rd_byte};
        end
    end
endmodule
